// File: rtbic_pkg.sv
/*
 * rtbic_pkg: constants for the first terminal configuration register
 * (bus disable, interrupt pin mode, shutdown scope).
 * Assumes a word-addressed 16-bit host port; no other file needs more.
 */
package rtbic_pkg;

   // host port geometry
   localparam int unsigned ADDR_W = 15;
   localparam int unsigned DATA_W = 16;

   // register location (word address)
   localparam logic [ADDR_W-1:0] CFG1_ADDR = 15'h0000;

   // field positions inside terminal_config_one
   localparam int unsigned BIT_BUS_A_DISABLE     = 15;
   localparam int unsigned BIT_BUS_B_DISABLE     = 14;
   localparam int unsigned BIT_IRQ_LEVEL_SELECT  = 13;
   localparam int unsigned BIT_SHUTDOWN_SCOPE    = 12;

   // value after master reset
   localparam logic [DATA_W-1:0] CFG1_RESET = 16'h0000;

   // read data for any other address
   localparam logic [DATA_W-1:0] RDATA_IDLE = 16'h0000;

   // which bus a shutdown command names as inactive
   typedef enum logic {
      RTBIC_BUS_A,
      RTBIC_BUS_B
   } rtbic_bus_e;

endpackage : rtbic_pkg

// File: rtbic_cfg1.sv
/*
 * rtbic_cfg1: terminal_config_one register and the logic it steers:
 * per-bus transmitter/receiver enables, interrupt pin pulse/level mode,
 * and automatic shutdown of the inactive bus on shutdown mode commands.
 * Assumes host port strobes and protocol events come from CLK_SYS logic;
 * the two transmit-block pins are asynchronous and are synchronised here.
 */
// Notes on behaviour
// - bus A disable bit 15 turns off bus A transmitter and receiver.
// - bus A transmitter off if disable bit or bus A block pin is set.
// - bus A block pin never touches the bus A receiver.
// - bus B disable bit 14 turns off bus B transmitter and receiver.
// - bus B transmitter off if disable bit or bus B block pin is set.
// - bus B block pin never touches the bus B receiver.
// - bit 13 low: message and hardware interrupt pins give pulses.
// - bit 13 high: interrupt pins hold until host acknowledges.
// - auto shutdown enabled, scope bit 0: command kills inactive bus rx and tx.
// - after master reset scope bit and auto shutdown default give full shutdown.
// - only master reset clears the register; nothing else resets it.
// - 16-bit host read-write register, active high, host-maintained only.
// - scope bit 1: command mutes inactive bus transmitter, receiver stays on.
`timescale 1ns/1ps

module rtbic_cfg1 (
   // clock, master reset, clock enable
   input  wire logic                        CLK_SYS,
   input  wire logic                        RST,
   input  wire logic                        CE,
   // host port
   input  wire logic [rtbic_pkg::ADDR_W-1:0] HOST_ADDR,
   input  wire logic                        HOST_WR,
   input  wire logic                        HOST_RD,
   input  wire logic [rtbic_pkg::DATA_W-1:0] HOST_WDATA,
   output logic      [rtbic_pkg::DATA_W-1:0] HOST_RDATA,
   // external transmit-block pins (asynchronous)
   input  wire logic                        BUS_A_TX_BLOCK_PIN,
   input  wire logic                        BUS_B_TX_BLOCK_PIN,
   // shutdown control from protocol logic
   input  wire logic                        AUTO_SHUTDOWN_DISABLE,
   input  wire logic                        SHUTDOWN_CMD,
   input  wire rtbic_pkg::rtbic_bus_e       SHUTDOWN_BUS,
   input  wire logic                        SHUTDOWN_RESTORE,
   // interrupt events and acknowledges
   input  wire logic                        MESSAGE_IRQ_EVT,
   input  wire logic                        HARDWARE_IRQ_EVT,
   input  wire logic                        MESSAGE_IRQ_ACK,
   input  wire logic                        HARDWARE_IRQ_ACK,
   output logic                             MESSAGE_IRQ_PIN,
   output logic                             HARDWARE_IRQ_PIN,
   // bus enables to the encoders/decoders
   output logic                             BUS_A_TX_EN,
   output logic                             BUS_A_RX_EN,
   output logic                             BUS_B_TX_EN,
   output logic                             BUS_B_RX_EN
);
   import rtbic_pkg::*;

   typedef struct packed {
      logic [DATA_W-1:0] cfg;       // terminal_config_one
      logic [DATA_W-1:0] rdata;     // registered read data
      logic [1:0]        blk_a;     // synchroniser, [0] is first stage
      logic [1:0]        blk_b;
      logic              sd_tx_a;   // shutdown state per bus
      logic              sd_rx_a;
      logic              sd_tx_b;
      logic              sd_rx_b;
      logic              irq_msg;
      logic              irq_hw;
   } rtbic_state_s;

   rtbic_state_s st_r;
   rtbic_state_s st_nxt;

   // word decode, shared by the read and write paths
   function automatic logic is_cfg1(input logic [ADDR_W-1:0] a);
      return a == CFG1_ADDR;
   endfunction : is_cfg1

   // one interrupt pin: pulse mode follows the event for one cycle,
   // level mode holds until acknowledged; a fresh event beats the ack
   function automatic logic irq_next(input logic cur, input logic lvl,
                                     input logic evt, input logic ack);
      if (!lvl) begin
         return evt;
      end
      return evt | (cur & ~ack);
   endfunction : irq_next

   logic lvl_mode;
   logic scope_tx_only;
   logic auto_sd;
   assign lvl_mode      = st_r.cfg[BIT_IRQ_LEVEL_SELECT];
   assign scope_tx_only = st_r.cfg[BIT_SHUTDOWN_SCOPE];
   assign auto_sd       = ~AUTO_SHUTDOWN_DISABLE;

   // next state
   always_comb begin
      st_nxt = st_r;
      // only stage two of each synchroniser feeds logic
      st_nxt.blk_a = {st_r.blk_a[0], BUS_A_TX_BLOCK_PIN};
      st_nxt.blk_b = {st_r.blk_b[0], BUS_B_TX_BLOCK_PIN};
      // host access; register is touched only by the host port
      if (HOST_WR && is_cfg1(HOST_ADDR)) begin
         st_nxt.cfg = HOST_WDATA;
      end
      if (HOST_RD) begin
         st_nxt.rdata = is_cfg1(HOST_ADDR) ? st_r.cfg : RDATA_IDLE;
      end
      // restore first, so a shutdown in the same cycle wins
      if (SHUTDOWN_RESTORE) begin
         st_nxt.sd_tx_a = 1'b0;
         st_nxt.sd_rx_a = 1'b0;
         st_nxt.sd_tx_b = 1'b0;
         st_nxt.sd_rx_b = 1'b0;
      end
      // command ignored when automatic shutdown is disabled
      if (SHUTDOWN_CMD && auto_sd) begin
         if (SHUTDOWN_BUS == RTBIC_BUS_A) begin
            st_nxt.sd_tx_a = 1'b1;
            st_nxt.sd_rx_a = st_r.sd_rx_a | ~scope_tx_only;
         end else begin
            st_nxt.sd_tx_b = 1'b1;
            st_nxt.sd_rx_b = st_r.sd_rx_b | ~scope_tx_only;
         end
      end
      st_nxt.irq_msg = irq_next(st_r.irq_msg, lvl_mode,
                                MESSAGE_IRQ_EVT, MESSAGE_IRQ_ACK);
      st_nxt.irq_hw  = irq_next(st_r.irq_hw, lvl_mode,
                                HARDWARE_IRQ_EVT, HARDWARE_IRQ_ACK);
   end

   // state register; master reset is the only reset, CE freezes all
   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         st_r       <= '0;
         st_r.cfg   <= CFG1_RESET;
         st_r.rdata <= RDATA_IDLE;
      end else if (CE) begin
         st_r <= st_nxt;
      end
   end

   // enables: the block pin gates only the transmitter
   assign BUS_A_TX_EN = ~(st_r.cfg[BIT_BUS_A_DISABLE] | st_r.blk_a[1]
                          | st_r.sd_tx_a);
   assign BUS_A_RX_EN = ~(st_r.cfg[BIT_BUS_A_DISABLE]
                          | st_r.sd_rx_a);
   assign BUS_B_TX_EN = ~(st_r.cfg[BIT_BUS_B_DISABLE] | st_r.blk_b[1]
                          | st_r.sd_tx_b);
   assign BUS_B_RX_EN = ~(st_r.cfg[BIT_BUS_B_DISABLE]
                          | st_r.sd_rx_b);

   assign HOST_RDATA       = st_r.rdata;
   assign MESSAGE_IRQ_PIN  = st_r.irq_msg;
   assign HARDWARE_IRQ_PIN = st_r.irq_hw;

   // checks
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (RST);

   AST_A_DIS: assert property (
      st_r.cfg[BIT_BUS_A_DISABLE] |-> !BUS_A_TX_EN && !BUS_A_RX_EN)
      else $error("bus A active while disabled");
   AST_A_PIN: assert property (
      (CE && BUS_A_TX_BLOCK_PIN) ##1 (CE && BUS_A_TX_BLOCK_PIN)
      |=> !BUS_A_TX_EN)
      else $error("bus A transmit not blocked by pin");
   AST_A_RX_FREE: assert property (
      (!st_r.cfg[BIT_BUS_A_DISABLE] && !st_r.sd_rx_a) |-> BUS_A_RX_EN)
      else $error("bus A receiver off without cause");
   AST_B_DIS: assert property (
      st_r.cfg[BIT_BUS_B_DISABLE] |-> !BUS_B_TX_EN && !BUS_B_RX_EN)
      else $error("bus B active while disabled");
   AST_B_PIN: assert property (
      (CE && BUS_B_TX_BLOCK_PIN) ##1 (CE && BUS_B_TX_BLOCK_PIN)
      |=> !BUS_B_TX_EN)
      else $error("bus B transmit not blocked by pin");
   AST_B_RX_FREE: assert property (
      (!st_r.cfg[BIT_BUS_B_DISABLE] && !st_r.sd_rx_b) |-> BUS_B_RX_EN)
      else $error("bus B receiver off without cause");
   AST_PULSE: assert property (
      (CE && !lvl_mode && MESSAGE_IRQ_EVT) |=>
      MESSAGE_IRQ_PIN ##1 (!CE || MESSAGE_IRQ_EVT || !MESSAGE_IRQ_PIN))
      else $error("pulse interrupt not one cycle");
   AST_LEVEL_HOLD: assert property (
      (CE && lvl_mode && HARDWARE_IRQ_PIN && !HARDWARE_IRQ_ACK)
      |=> HARDWARE_IRQ_PIN)
      else $error("level interrupt dropped without ack");
   AST_SD_FULL: assert property (
      (CE && SHUTDOWN_CMD && !AUTO_SHUTDOWN_DISABLE && !scope_tx_only
       && SHUTDOWN_BUS == RTBIC_BUS_B)
      |=> !BUS_B_TX_EN && !BUS_B_RX_EN)
      else $error("full shutdown of bus B missing");
   AST_SD_MUTE: assert property (
      (CE && SHUTDOWN_CMD && !AUTO_SHUTDOWN_DISABLE && scope_tx_only
       && SHUTDOWN_BUS == RTBIC_BUS_A && !st_r.sd_rx_a && !HOST_WR
       && !st_r.cfg[BIT_BUS_A_DISABLE])
      |=> !BUS_A_TX_EN && BUS_A_RX_EN)
      else $error("mute shutdown of bus A wrong");
   AST_RST_VAL: assert property (@(posedge CLK_SYS)
      $fell(RST) |-> st_r.cfg == CFG1_RESET)
      else $error("register not cleared by master reset");
   AST_WR_RD: assert property (
      (CE && HOST_WR && is_cfg1(HOST_ADDR)) ##1
      (CE && HOST_RD && !HOST_WR && is_cfg1(HOST_ADDR))
      |=> HOST_RDATA == $past(HOST_WDATA, 2))
      else $error("readback differs from write");
   AST_HOLD: assert property (
      (!HOST_WR || !CE) |=> st_r.cfg == $past(st_r.cfg))
      else $error("register changed without host write");

   COV_FULL_SD: cover property (CE && SHUTDOWN_CMD && !scope_tx_only);
   COV_MUTE_SD: cover property (CE && SHUTDOWN_CMD && scope_tx_only);
   COV_LEVEL_ACK: cover property (lvl_mode && MESSAGE_IRQ_PIN
                                  ##1 !MESSAGE_IRQ_PIN);

endmodule : rtbic_cfg1

// File: rtbic_host_model.sv
/* rtbic_host_model: host processor on the register port, whole words
   only. assumes callers enter its tasks just after a rising edge. */
`timescale 1ns/1ps
module rtbic_host_model (
   // clock
   input  wire logic                    CLK_SYS,
   // host port
   output logic [rtbic_pkg::ADDR_W-1:0] HOST_ADDR,
   output logic                         HOST_WR,
   output logic                         HOST_RD,
   output logic [rtbic_pkg::DATA_W-1:0] HOST_WDATA,
   // interrupt acknowledges
   output logic                         MESSAGE_IRQ_ACK,
   output logic                         HARDWARE_IRQ_ACK
);
   import rtbic_pkg::*;
   // idle host: no strobes at time zero
   initial begin
      {HOST_WR, HOST_RD, MESSAGE_IRQ_ACK, HARDWARE_IRQ_ACK} = 4'h0;
      HOST_ADDR  = 15'h0000;
      HOST_WDATA = 16'h0000;
   end
   // 16-bit word held until the taking edge, then scrambled
   task automatic wr(input logic [ADDR_W-1:0] a,
                     input logic [DATA_W-1:0] d);
      HOST_ADDR  <= a;
      HOST_WDATA <= d;
      HOST_WR    <= 1'h1;
      @(posedge CLK_SYS);
      HOST_WR    <= 1'h0;
      HOST_WDATA <= ~d; // stale data must never be stored
      @(posedge CLK_SYS);
   endtask : wr
   // read strobe for one taken edge
   task automatic rd(input logic [ADDR_W-1:0] a);
      HOST_ADDR <= a;
      HOST_RD   <= 1'h1;
      @(posedge CLK_SYS);
      HOST_RD   <= 1'h0;
      HOST_ADDR <= ~a;
      @(posedge CLK_SYS);
   endtask : rd
   // write then read on the very next edge: readback path with no gap
   task automatic wrrd(input logic [ADDR_W-1:0] a,
                       input logic [DATA_W-1:0] d);
      HOST_ADDR  <= a;
      HOST_WDATA <= d;
      HOST_WR    <= 1'h1;
      @(posedge CLK_SYS);
      HOST_WR    <= 1'h0;
      HOST_WDATA <= ~d;
      HOST_RD    <= 1'h1;
      @(posedge CLK_SYS);
      HOST_RD    <= 1'h0;
      @(posedge CLK_SYS);
   endtask : wrrd
   // level mode needs the host to clear each pin
   task automatic ack(input logic msg);
      MESSAGE_IRQ_ACK  <= msg;
      HARDWARE_IRQ_ACK <= ~msg;
      @(posedge CLK_SYS);
      {MESSAGE_IRQ_ACK, HARDWARE_IRQ_ACK} <= 2'h0;
   endtask : ack
endmodule : rtbic_host_model

// File: testbench.sv
/* testbench: drives rtbic_cfg1 through the host model and its side
   inputs; expected results queue up and a monitor compares them. */
`timescale 1ns/1ps
module testbench;
   import rtbic_pkg::*;
   logic CLK_SYS, RST, CE, blk_a, blk_b, asd, cmd, rst_sd, mevt, hevt;
   logic rd_d;
   rtbic_bus_e sbus;
   logic [ADDR_W-1:0] addr;
   logic wr, rd, mack, hack, atx, arx, btx, brx, mpin, hpin;
   logic [DATA_W-1:0] wdata, rdata, d;
   logic [DATA_W-1:0] qr[$];
   logic [5:0] qs[$];
   int fail_count, compares, cycles, seed, b;
   rtbic_host_model host (.CLK_SYS(CLK_SYS), .HOST_ADDR(addr),
      .HOST_WR(wr), .HOST_RD(rd), .HOST_WDATA(wdata),
      .MESSAGE_IRQ_ACK(mack), .HARDWARE_IRQ_ACK(hack));
   rtbic_cfg1 DUT (.CLK_SYS(CLK_SYS), .RST(RST), .CE(CE), .HOST_ADDR(addr),
      .HOST_WR(wr), .HOST_RD(rd), .HOST_WDATA(wdata), .HOST_RDATA(rdata),
      .BUS_A_TX_BLOCK_PIN(blk_a), .BUS_B_TX_BLOCK_PIN(blk_b),
      .AUTO_SHUTDOWN_DISABLE(asd), .SHUTDOWN_CMD(cmd), .SHUTDOWN_BUS(sbus),
      .SHUTDOWN_RESTORE(rst_sd), .MESSAGE_IRQ_EVT(mevt),
      .HARDWARE_IRQ_EVT(hevt), .MESSAGE_IRQ_ACK(mack),
      .HARDWARE_IRQ_ACK(hack), .MESSAGE_IRQ_PIN(mpin),
      .HARDWARE_IRQ_PIN(hpin), .BUS_A_TX_EN(atx), .BUS_A_RX_EN(arx),
      .BUS_B_TX_EN(btx), .BUS_B_RX_EN(brx));
   // 100 MHz clock
   initial begin
      CLK_SYS = 1'h0;
      forever #5 CLK_SYS = ~CLK_SYS;
   end
   task automatic test_done;
      if (fail_count == 0 && compares > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : test_done
   task automatic cmp16(string n, logic [15:0] e, logic [15:0] s);
      compares++;
      if (s !== e) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask : cmp16
   task automatic cmp6(string n, logic [5:0] e, logic [5:0] s);
      compares++;
      if (s !== e) begin
         fail_count++;
         $display("mismatch %s expected %b seen %b", n, e, s);
      end
   endtask : cmp6
   // note {a_tx,a_rx,b_tx,b_rx,msg,hw} for the next falling edge
   task automatic chk(logic [5:0] v);
      qs.push_back(v);
      @(posedge CLK_SYS);
   endtask : chk
   task automatic rdx(logic [ADDR_W-1:0] a, logic [DATA_W-1:0] e);
      qr.push_back(e);
      host.rd(a);
   endtask : rdx
   // pulse both event inputs for one taken edge
   task automatic irq;
      {mevt, hevt} <= 2'h3;
      @(posedge CLK_SYS);
      {mevt, hevt} <= 2'h0;
   endtask : irq
   task automatic shut(rtbic_bus_e bus);
      sbus <= bus;
      cmd  <= 1'h1;
      @(posedge CLK_SYS);
      cmd  <= 1'h0;
   endtask : shut
   // read data lands on the edge that takes the read
   always @(posedge CLK_SYS) rd_d <= rd;
   always @(negedge CLK_SYS) begin
      if (rd_d && qr.size() > 0) cmp16("rdata", qr.pop_front(), rdata);
      if (qs.size() > 0)
         cmp6("enables_irq", qs.pop_front(), {atx,arx,btx,brx,mpin,hpin});
   end
   // hang guard, far above the hundred or so cycles needed
   always @(posedge CLK_SYS) begin
      cycles++;
      if (cycles == 5000) begin
         fail_count++;
         test_done;
      end
   end
   initial begin
      {blk_a, blk_b, asd, cmd, rst_sd, mevt, hevt} = 7'h00;
      {RST, CE, sbus} = {2'h3, RTBIC_BUS_A};
      seed = 47;
      repeat (2) @(posedge CLK_SYS);
      RST <= 1'h0;
      @(posedge CLK_SYS);
      chk(6'b111100);
      rdx(CFG1_ADDR, CFG1_RESET);
      for (b = 0; b < 4; b++) begin
         d = 16'($random(seed));
         host.wr(CFG1_ADDR, d);
         rdx(CFG1_ADDR, d);
      end
      host.wr(15'h0001, 16'hFFFF);
      rdx(CFG1_ADDR, d);
      rdx(15'h0001, RDATA_IDLE);
      for (b = 0; b < 2; b++) begin
         host.wr(CFG1_ADDR, 16'h8000 >> b);
         chk(b ? 6'b110000 : 6'b001100);
         host.wr(CFG1_ADDR, 16'h0000);
         {blk_b, blk_a} <= b ? 2'h2 : 2'h1;
         repeat (4) @(posedge CLK_SYS);
         chk(b ? 6'b110100 : 6'b011100);
         {blk_b, blk_a} <= 2'h0;
         repeat (4) @(posedge CLK_SYS);
      end
      irq;
      chk(6'b111111);
      chk(6'b111100);
      host.wr(CFG1_ADDR, 16'h2000);
      irq;
      chk(6'b111111);
      chk(6'b111111);
      host.ack(1'h1);
      chk(6'b111101);
      host.ack(1'h0);
      chk(6'b111100);
      host.wr(CFG1_ADDR, 16'h0000);
      asd <= 1'h1;
      shut(RTBIC_BUS_B);
      asd <= 1'h0;
      chk(6'b111100);
      shut(RTBIC_BUS_B);
      chk(6'b110000);
      rst_sd <= 1'h1;
      @(posedge CLK_SYS);
      rst_sd <= 1'h0;
      host.wr(CFG1_ADDR, 16'h1000);
      shut(RTBIC_BUS_A);
      chk(6'b011100);
      // mid-run master reset clears register and shutdown state
      RST <= 1'h1;
      repeat (2) @(posedge CLK_SYS);
      RST <= 1'h0;
      @(posedge CLK_SYS);
      chk(6'b111100);
      rdx(CFG1_ADDR, CFG1_RESET);
      // clock enable low: the write must be ignored
      CE <= 1'h0;
      host.wr(CFG1_ADDR, 16'hFFFF);
      CE <= 1'h1;
      rdx(CFG1_ADDR, CFG1_RESET);
      d = 16'($random(seed));
      qr.push_back(d);
      host.wrrd(CFG1_ADDR, d);
      test_done;
   end
endmodule : testbench
